// ==== src/zt_xor_params.svh ====
// Constants for the zero-test-skip and xor-literal execute block.
`ifndef ZT_XOR_PARAMS_SVH
`define ZT_XOR_PARAMS_SVH
`define ZTS_OPC_HI 7'h33
`define XOR_OPC_HI 8'h0a
`define NOP_WORD 16'h0000
`define IDX_LIMIT 8'h5f
`define ACC_RST 8'h00
`define BANK_RST 4'h0
`define PTR_RST 21'h000000
`define CLK_NS 20
`define PHASES 4
`define REG_RD_OFF 32'h00000000
`define REG_ACC 32'h00000000
`define REG_BANK 32'h00000004
`define REG_STAT 32'h00000008
`define REG_TLAT 32'h0000000c
`define REG_TPTR 32'h00000010
`define REG_CTRL 32'h00000014
`define REG_HOLD 32'h00000018
`define REG_LAST 32'h0000001c
`endif

// ==== src/zt_xor_pkg.sv ====
// Types for the zero-test-skip and xor-literal execute block.
package zt_xor_pkg;
    typedef enum logic [1:0] {PH_DECODE, PH_READ, PH_PROC, PH_WRITE} phase_t;
    typedef enum logic [1:0] {EX_RUN, EX_SKIP1, EX_SKIP2} exec_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [3:0] bank;
        logic access_bank;
        logic indexed;
        logic rd;
    } mem_req_t;
endpackage

// ==== src/zt_xor_exec.sv ====
// Decode and execute logic for zero-test-skip, xor-literal and table write.
//
// Chosen here: the Wishbone slave port and the address map.
`timescale 1ns/1ns
`include "zt_xor_params.svh"
// How it works
// RULE1: Upper seven bits 0110011 decode zero-test-skip; next bit bank select; low byte address.
// RULE2: Zero operand discards prefetched word, runs a no-op; instruction takes two cycles.
// RULE3: Skipped two-word instruction costs one more no-op cycle, three total.
// RULE4: Selector 0 uses shared access bank; selector 1 uses bank pick register.
// RULE5: Extended set, selector 0, address at most 95 means indexed literal offset.
// RULE6: Xor-literal XORs accumulator with the 8-bit literal, result back to accumulator.
// RULE7: Upper byte 00001010 decodes xor-literal; literal in low byte.
// RULE8: Xor-literal sets negative from bit 7, zero from result, others unchanged.
// RULE9: Phase one decodes, two reads, three processes, four writes or idles.
// RULE10: Table write copies latch byte to holding; pointer post or pre incremented.
module zt_xor_exec (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [15:0] instr_i,
    input wire logic instr_valid_i,
    input wire logic next_two_word_i,
    input wire logic [7:0] mem_rdata_i,
    input wire logic [31:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [3:0] sel_i,
    input wire logic we_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    output zt_xor_pkg::mem_req_t mem_req_o,
    output zt_xor_pkg::phase_t phase_o,
    output logic busy_o,
    output logic [7:0] acc_o,
    output logic [31:0] dat_o,
    output logic ack_o
);
    import zt_xor_pkg::*;

    // ****************************************
    // Phase and execute state
    // ****************************************
    phase_t ph_q, ph_d;
    exec_t ex_q, ex_d;
    logic [15:0] ir_q, ir_d;
    logic is_zts, is_xor, is_tbw;
    logic [7:0] acc_q, acc_d;
    logic neg_q, neg_d, zero_q, zero_d;
    logic [7:0] opnd_q, opnd_d;
    logic [3:0] bank_q, bank_d;
    logic xinst_q, xinst_d;
    logic [7:0] tlat_q, tlat_d;
    logic [20:0] tptr_q, tptr_d;
    logic [7:0] hold_q, hold_d;
    logic [20:0] hold_at_q, hold_at_d;
    logic [1:0] skips_q, skips_d;
    mem_req_t req_q, req_d;
    logic ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;
    logic [7:0] res;
    logic bus_wr, bus_rd;
    logic busy_q, busy_d;

    // Opcode recognition on the latched instruction word.
    assign is_zts = (ir_q[15:9] == `ZTS_OPC_HI); // RULE1
    assign is_xor = (ir_q[15:8] == `XOR_OPC_HI); // RULE7
    // Table write family: 0000 0000 0000 11nn.
    assign is_tbw = (ir_q[15:2] == 14'h0003);
    assign res = acc_q ^ ir_q[7:0]; // RULE6
    assign bus_wr = cyc_i && stb_i && we_i && !ack_q;
    assign bus_rd = cyc_i && stb_i && !we_i && !ack_q;

    // Next-state logic for the four-phase execute sequencer and registers.
    always_comb begin
        ph_d = ph_q;
        ex_d = ex_q;
        ir_d = ir_q;
        acc_d = acc_q;
        neg_d = neg_q;
        zero_d = zero_q;
        opnd_d = opnd_q;
        bank_d = bank_q;
        xinst_d = xinst_q;
        tlat_d = tlat_q;
        tptr_d = tptr_q;
        hold_d = hold_q;
        hold_at_d = hold_at_q;
        skips_d = skips_q;
        req_d = '0;
        case (ph_q) // RULE9
            PH_DECODE: begin
                if (ex_q != EX_RUN) begin
                    ph_d = PH_READ;
                end else if (instr_valid_i) begin
                    ir_d = instr_i;
                    ph_d = PH_READ;
                end
            end
            PH_READ: begin
                ph_d = PH_PROC;
                if (ex_q == EX_RUN && is_zts) begin
                    req_d.addr = ir_q[7:0];
                    req_d.access_bank = !ir_q[8]; // RULE4
                    req_d.bank = ir_q[8] ? bank_q : 4'h0; // RULE4
                    req_d.indexed = xinst_q && !ir_q[8] && (ir_q[7:0] <= `IDX_LIMIT); // RULE5
                    req_d.rd = 1'b1;
                end
            end
            PH_PROC: begin
                ph_d = PH_WRITE;
                if (ex_q == EX_RUN && is_zts) begin
                    opnd_d = mem_rdata_i;
                end
            end
            PH_WRITE: begin
                ph_d = PH_DECODE;
                case (ex_q)
                    EX_RUN: begin
                        if (is_xor) begin
                            acc_d = res; // RULE6
                            neg_d = res[7]; // RULE8
                            zero_d = (res == 8'h00); // RULE8
                        end else if (is_zts && opnd_q == 8'h00) begin
                            ex_d = EX_SKIP1; // RULE2
                            skips_d = skips_q + 2'h1;
                        end else if (is_tbw) begin
                            // RULE10
                            if (ir_q[1:0] == 2'h3) begin
                                hold_d = tlat_q;
                                hold_at_d = tptr_q + 21'h000001;
                                tptr_d = tptr_q + 21'h000001;
                            end else begin
                                hold_d = tlat_q;
                                hold_at_d = tptr_q;
                                if (ir_q[1:0] == 2'h1) begin
                                    tptr_d = tptr_q + 21'h000001;
                                end else if (ir_q[1:0] == 2'h2) begin
                                    tptr_d = tptr_q - 21'h000001;
                                end
                            end
                        end
                    end
                    EX_SKIP1: begin
                        ex_d = next_two_word_i ? EX_SKIP2 : EX_RUN; // RULE3
                        ir_d = `NOP_WORD;
                    end
                    default: begin
                        ex_d = EX_RUN;
                        ir_d = `NOP_WORD;
                    end
                endcase
            end
            default: ph_d = PH_DECODE;
        endcase
        // Bus writes to the software-visible registers.
        if (bus_wr) begin
            case (adr_i)
                `REG_ACC: if (sel_i[0]) acc_d = dat_i[7:0];
                `REG_BANK: if (sel_i[0]) bank_d = dat_i[3:0];
                `REG_TLAT: if (sel_i[0]) tlat_d = dat_i[7:0];
                `REG_TPTR: tptr_d = dat_i[20:0];
                `REG_CTRL: if (sel_i[0]) xinst_d = dat_i[0];
                default: ;
            endcase
        end
        // Busy follows the next execute state so that the output leaves a flop.
        busy_d = (ex_d != EX_RUN);
    end

    // Wishbone classic slave answer path: ack one cycle after the strobe.
    always_comb begin
        ack_d = cyc_i && stb_i && !ack_q;
        rdat_d = 32'h00000000;
        if (bus_rd) begin
            case (adr_i)
                `REG_ACC: rdat_d = {24'h000000, acc_q};
                `REG_BANK: rdat_d = {28'h0000000, bank_q};
                `REG_STAT: rdat_d = {28'h0000000, skips_q, neg_q, zero_q};
                `REG_TLAT: rdat_d = {24'h000000, tlat_q};
                `REG_TPTR: rdat_d = {11'h000, tptr_q};
                `REG_CTRL: rdat_d = {31'h00000000, xinst_q};
                `REG_HOLD: rdat_d = {24'h000000, hold_q};
                `REG_LAST: rdat_d = {11'h000, hold_at_q};
                default: rdat_d = 32'h00000000;
            endcase
        end
    end

    // State registers with synchronous reset.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ph_q <= PH_DECODE;
            ex_q <= EX_RUN;
            ir_q <= `NOP_WORD;
            acc_q <= `ACC_RST;
            neg_q <= 1'b0;
            zero_q <= 1'b0;
            opnd_q <= 8'h00;
            bank_q <= `BANK_RST;
            xinst_q <= 1'b0;
            tlat_q <= 8'h00;
            tptr_q <= `PTR_RST;
            hold_q <= 8'h00;
            hold_at_q <= `PTR_RST;
            skips_q <= 2'h0;
            req_q <= '0;
            ack_q <= 1'b0;
            rdat_q <= 32'h00000000;
            busy_q <= 1'b0;
        end else begin
            ph_q <= ph_d;
            ex_q <= ex_d;
            ir_q <= ir_d;
            acc_q <= acc_d;
            neg_q <= neg_d;
            zero_q <= zero_d;
            opnd_q <= opnd_d;
            bank_q <= bank_d;
            xinst_q <= xinst_d;
            tlat_q <= tlat_d;
            tptr_q <= tptr_d;
            hold_q <= hold_d;
            hold_at_q <= hold_at_d;
            skips_q <= skips_d;
            req_q <= req_d;
            ack_q <= ack_d;
            rdat_q <= rdat_d;
            busy_q <= busy_d;
        end
    end

    // Outputs straight from flip-flops.
    assign mem_req_o = req_q;
    assign phase_o = ph_q;
    assign busy_o = busy_q;
    assign acc_o = acc_q;
    assign dat_o = rdat_q;
    assign ack_o = ack_q;

    // ****************************************
    // Assertions
    // ****************************************
    chk_zts_decode: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
        (ph_q == PH_READ && ex_q == EX_RUN && ir_q[15:9] == 7'h33) |=> mem_req_o.rd)
        else $error("zero test did not read its operand");
    chk_skip_entry: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2
        (ph_q == PH_WRITE && ex_q == EX_RUN && is_zts && opnd_q == 8'h00)
        |=> ex_q == EX_SKIP1 ##4 ex_q != EX_SKIP1)
        else $error("skip cycle not taken");
    chk_skip_two: assert property (@(posedge clk_i) disable iff (rst_i) // RULE3
        (ph_q == PH_WRITE && ex_q == EX_SKIP1 && next_two_word_i) |=> ex_q == EX_SKIP2)
        else $error("second skip cycle missing");
    chk_bank_sel: assert property (@(posedge clk_i) disable iff (rst_i) // RULE4
        $rose(mem_req_o.rd) |-> mem_req_o.access_bank == !ir_q[8])
        else $error("bank selection wrong");
    chk_indexed: assert property (@(posedge clk_i) disable iff (rst_i) // RULE5
        (mem_req_o.rd && mem_req_o.indexed) |-> (xinst_q && mem_req_o.addr <= 8'h5f))
        else $error("indexed mode outside range");
    chk_xor_acc: assert property (@(posedge clk_i) disable iff (rst_i || bus_wr) // RULE6
        (ph_q == PH_WRITE && ex_q == EX_RUN && is_xor)
        |=> acc_q == ($past(acc_q) ^ $past(ir_q[7:0])))
        else $error("xor result wrong");
    chk_xor_flags: assert property (@(posedge clk_i) disable iff (rst_i) // RULE8
        (ph_q == PH_WRITE && ex_q == EX_RUN && is_xor)
        |=> (neg_q == ($past(acc_q[7]) ^ $past(ir_q[7])))
        && (zero_q == ($past(acc_q) == $past(ir_q[7:0]))))
        else $error("xor flags wrong");
    chk_phase_walk: assert property (@(posedge clk_i) disable iff (rst_i) // RULE9
        (ph_q == PH_READ) |=> ph_q == PH_PROC ##1 ph_q == PH_WRITE ##1 ph_q == PH_DECODE)
        else $error("phase order broken");
    chk_tbw_copy: assert property (@(posedge clk_i) disable iff (rst_i) // RULE10
        (ph_q == PH_WRITE && ex_q == EX_RUN && is_tbw) |=> hold_q == $past(tlat_q))
        else $error("table write did not copy latch");
    // Only the xor literal may move the accumulator at the write phase.
    chk_acc_hold: assert property (@(posedge clk_i) disable iff (rst_i || bus_wr) // RULE7
        (ph_q == PH_WRITE && !(ex_q == EX_RUN && ir_q[15:8] == 8'h0a))
        |=> acc_q == $past(acc_q))
        else $error("accumulator changed without xor literal");
    // Skip cycles behave as no-ops and end when they should.
    chk_skip_quiet: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2
        (ex_q != EX_RUN) |=> !mem_req_o.rd)
        else $error("memory read during a skip cycle");
    chk_no_skip: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2
        (ph_q == PH_WRITE && ex_q == EX_RUN && ir_q[15:9] == 7'h33 && opnd_q != 8'h00)
        |=> ex_q == EX_RUN)
        else $error("skip taken on nonzero operand");
    chk_skip_single: assert property (@(posedge clk_i) disable iff (rst_i) // RULE3
        (ph_q == PH_WRITE && ex_q == EX_SKIP1 && !next_two_word_i) |=> ex_q == EX_RUN)
        else $error("extra skip cycle after one-word instruction");
    chk_skip_end: assert property (@(posedge clk_i) disable iff (rst_i) // RULE3
        (ph_q == PH_WRITE && ex_q == EX_SKIP2) |=> ex_q == EX_RUN)
        else $error("skip did not end after the second cycle");
    // Operand request fields follow the selector and the extended-set switch; flags hold outside xor literal; reads fall in the process phase.
    chk_bank_field: assert property (@(posedge clk_i) disable iff (rst_i) // RULE4
        $rose(mem_req_o.rd) |-> mem_req_o.bank == (ir_q[8] ? bank_q : 4'h0))
        else $error("bank field wrong on operand read");
    chk_idx_taken: assert property (@(posedge clk_i) disable iff (rst_i) // RULE5
        ($rose(mem_req_o.rd) && xinst_q && !ir_q[8] && ir_q[7:0] <= 8'h5f)
        |-> mem_req_o.indexed)
        else $error("indexed mode not taken");
    chk_flags_keep: assert property (@(posedge clk_i) disable iff (rst_i) // RULE8
        (ph_q != PH_WRITE || ex_q != EX_RUN || ir_q[15:8] != 8'h0a)
        |=> neg_q == $past(neg_q) && zero_q == $past(zero_q))
        else $error("flags changed outside xor literal");
    chk_read_phase: assert property (@(posedge clk_i) disable iff (rst_i) // RULE9
        mem_req_o.rd |-> ph_q == PH_PROC)
        else $error("operand read outside process phase");
    // Table pointer moves after the copy for post-increment, before it for pre-increment.
    chk_ptr_post: assert property (@(posedge clk_i) disable iff (rst_i || bus_wr) // RULE10
        (ph_q == PH_WRITE && ex_q == EX_RUN && ir_q == 16'h000d)
        |=> tptr_q == $past(tptr_q) + 21'h000001 && hold_at_q == $past(tptr_q))
        else $error("post-increment table write wrong");
    chk_ptr_pre: assert property (@(posedge clk_i) disable iff (rst_i || bus_wr) // RULE10
        (ph_q == PH_WRITE && ex_q == EX_RUN && ir_q == 16'h000f)
        |=> tptr_q == $past(tptr_q) + 21'h000001 && hold_at_q == $past(tptr_q) + 21'h000001)
        else $error("pre-increment table write wrong");
    // The bus answer is a single-cycle pulse.
    chk_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
endmodule

// ==== tb/data_mem_model.sv ====
// Behavioural data memory that answers the block's operand reads.
`timescale 1ns/1ns
module data_mem_model (
    input wire logic clk_i,
    input wire zt_xor_pkg::mem_req_t mem_req_i,
    output logic [7:0] rdata_o,
    output zt_xor_pkg::mem_req_t last_req_o
);
    import zt_xor_pkg::*;
    logic [7:0] mem [0:255];
    logic [7:0] stale_q;
    // ****************************************************************
    // Read port
    // ****************************************************************
    // Data is only valid while a read is asked; otherwise the inverse shows.
    always_comb begin
        rdata_o = mem_req_i.rd ? mem[mem_req_i.addr] : stale_q;
    end
    // Remember the last request so the bench can check its address fields.
    always_ff @(posedge clk_i) begin
        stale_q <= ~rdata_o;
        if (mem_req_i.rd) begin
            last_req_o <= mem_req_i;
        end
    end
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the zero-test-skip and xor-literal block.
`timescale 1ns/1ns
`define CHK(what, exp, got) begin n_checks++; if ((got) !== (exp)) begin fail_count++; \
    $display("[FAIL] %s expected %h seen %h", what, exp, got); end end
module tb_top;
    import zt_xor_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [15:0] instr_i = 16'h0000;
    logic instr_valid_i = 1'b0;
    logic next_two_word_i = 1'b0;
    logic [7:0] mem_rdata_i;
    logic [31:0] adr_i = 32'h00000000;
    logic [31:0] dat_i = 32'h00000000;
    logic [3:0] sel_i = 4'h0;
    logic we_i = 1'b0;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    mem_req_t mem_req_o;
    mem_req_t last_req;
    phase_t phase_o;
    logic busy_o;
    logic [7:0] acc_o;
    logic [31:0] dat_o;
    logic ack_o;
    logic [31:0] q;
    int fail_count = 0;
    int n_checks = 0;
    int nb;
    // Clock at 50 MHz.
    always #10 clk_i = ~clk_i;
    zt_xor_exec i_dut (.clk_i(clk_i), .rst_i(rst_i), .instr_i(instr_i),
        .instr_valid_i(instr_valid_i), .next_two_word_i(next_two_word_i),
        .mem_rdata_i(mem_rdata_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .mem_req_o(mem_req_o), .phase_o(phase_o),
        .busy_o(busy_o), .acc_o(acc_o), .dat_o(dat_o), .ack_o(ack_o));
    data_mem_model i_mem (.clk_i(clk_i), .mem_req_i(mem_req_o), .rdata_o(mem_rdata_i),
        .last_req_o(last_req));
    // ****************************************************************
    // Tasks
    // ****************************************************************
    // One classic bus cycle; the request stands until ack is sampled high.
    task automatic wb(input logic [31:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        adr_i <= a;
        we_i <= w;
        dat_i <= d;
        sel_i <= 4'hf;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        q = dat_o;
        if (n >= 50) fail_count++;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask
    // Hands one word over at decode and counts the busy clocks that follow, four per skip cycle.
    task automatic run(input logic [15:0] w, input logic two);
        int n;
        n = 0;
        nb = 0;
        do begin
            @(posedge clk_i);
            #1;
            n++;
        end while (!(phase_o === PH_DECODE && busy_o === 1'b0) && n < 100);
        if (n >= 100) fail_count++;
        @(posedge clk_i);
        instr_i <= w;
        instr_valid_i <= 1'b1;
        next_two_word_i <= two;
        @(posedge clk_i);
        instr_valid_i <= 1'b0;
        repeat (16) begin
            @(posedge clk_i);
            #1;
            if (busy_o === 1'b1) nb++;
        end
        @(posedge clk_i);
        next_two_word_i <= 1'b0;
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Cuts a hang short.
    initial begin
        #400000;
        fail_count++;
        wrap_up();
    end
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        i_mem.mem[8'h10] = 8'h00;
        i_mem.mem[8'h20] = 8'h05;
        i_mem.mem[8'h40] = 8'h00;
        i_mem.mem[8'h60] = 8'h3c; // Nonzero, so the test at this address does not skip.
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        `CHK("acc reset", 8'h00, acc_o)
        wb(32'h00, 1'b1, 32'hb5);
        run(16'h0aaf, 1'b0);
        `CHK("xor acc", 8'h1a, acc_o)
        wb(32'h08, 1'b0, 0);
        `CHK("flags nz", 32'h0, q)
        run(16'h0a1a, 1'b0);
        `CHK("xor zero", 8'h00, acc_o)
        wb(32'h08, 1'b0, 0);
        `CHK("flag z", 32'h1, q)
        run(16'h0a80, 1'b0);
        wb(32'h00, 1'b0, 0);
        `CHK("acc neg", 32'h80, q)
        wb(32'h04, 1'b1, 32'hf7);
        wb(32'h04, 1'b0, 0);
        `CHK("bank reg", 32'h7, q)
        run(16'h6710, 1'b0);
        `CHK("skip one", 4, nb)
        `CHK("bank sel", 1'b0, last_req.access_bank)
        `CHK("addr", 8'h10, last_req.addr)
        `CHK("bank pick", 4'h7, last_req.bank)
        run(16'h6720, 1'b1);
        `CHK("no skip", 0, nb)
        wb(32'h14, 1'b1, 32'h1);
        run(16'h6640, 1'b1);
        `CHK("skip two", 8, nb)
        `CHK("access", 1'b1, last_req.access_bank)
        `CHK("indexed", 1'b1, last_req.indexed)
        `CHK("access no bank", 4'h0, last_req.bank)
        run(16'h6660, 1'b0);
        `CHK("not idx", 1'b0, last_req.indexed)
        `CHK("skip5", 0, nb)
        wb(32'h08, 1'b0, 0);
        `CHK("status", 32'ha, q)
        wb(32'h0c, 1'b1, 32'h55);
        wb(32'h10, 1'b1, 32'h00a356);
        run(16'h000d, 1'b0);
        wb(32'h18, 1'b0, 0);
        `CHK("hold post", 32'h55, q)
        wb(32'h1c, 1'b0, 0);
        `CHK("addr post", 32'h00a356, q)
        wb(32'h10, 1'b0, 0);
        `CHK("ptr post", 32'h00a357, q)
        wb(32'h0c, 1'b1, 32'h34);
        wb(32'h10, 1'b1, 32'h01389a);
        run(16'h000f, 1'b0);
        wb(32'h1c, 1'b0, 0);
        `CHK("addr pre", 32'h01389b, q)
        wb(32'h18, 1'b0, 0);
        `CHK("hold pre", 32'h34, q)
        run(16'h000e, 1'b0);
        wb(32'h1c, 1'b0, 0);
        `CHK("addr dec", 32'h01389b, q)
        wb(32'h10, 1'b0, 0);
        `CHK("ptr dec", 32'h01389a, q)
        run(16'h000c, 1'b0);
        wb(32'h1c, 1'b0, 0);
        `CHK("addr plain", 32'h01389a, q)
        wb(32'h10, 1'b0, 0);
        `CHK("ptr plain", 32'h01389a, q)
        wb(32'h20, 1'b0, 0);
        `CHK("unmapped", 32'h0, q)
        wrap_up();
    end
endmodule
